// [verif/ifs_chain_model.sv]
`timescale 1ns/1ps

// Far end of the chain link, clocked by the link clock
module ifs_chain_model (
	input wire logic linkClk,
	input wire logic stall,
	input wire logic reqCheck,
	input wire logic reqCrc,
	output logic chainSerialInput,
	output logic checkBitEvt,
	output logic crcEvt
);
	logic reqCheckQ = 1'b0;
	logic reqCrcQ = 1'b0;

	initial begin
		chainSerialInput = 1'b0;
		checkBitEvt = 1'b0;
		crcEvt = 1'b0;
	end

	// Line toggles while healthy; stall freezes it to mimic a stuck input
	// Requests are bench levels, so only their rising edge makes a pulse
	always @(posedge linkClk) begin
		if (!stall) begin
			chainSerialInput <= ~chainSerialInput;
		end
		reqCheckQ <= reqCheck;
		reqCrcQ <= reqCrc;
		checkBitEvt <= reqCheck & ~reqCheckQ;
		crcEvt <= reqCrc & ~reqCrcQ;
	end
endmodule // ifs_chain_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
`include "ifs_params.svh"

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
	logic clk = 1'b0;
	logic linkClk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic timeoutEnable = 1'b0;
	logic clearAllFlags = 1'b0;
	logic rdEn = 1'b0;
	logic [7:0] rdAddr = 8'h00;
	logic [9:0] txCount = 10'h000;
	logic [8:0] rxCount = 9'h000;
	ifs_pkg::ifs_host_evt_t hostEvt = 3'h0;
	ifs_pkg::ifs_queue_evt_t txEvt = 3'h0;
	ifs_pkg::ifs_queue_evt_t rxEvt = 3'h0;
	logic stall = 1'b0;
	logic reqCheck = 1'b0;
	logic reqCrc = 1'b0;
	logic chainSerialInput, linkCheckBitEvt, linkCrcEvt;
	logic [15:0] rdData;
	logic rdValid, spiErrorSummary, chainErrorSummary, txQueueErrorSummary, rxQueueErrorSummary;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [15:0] ifExp [3] = '{16'h0010, 16'h0100, 16'h0200};
	logic [9:0] txLvl [5] = '{10'h000, 10'h001, 10'h1FE, 10'h1FF, 10'h200};
	logic [8:0] txLvlExp [5] = '{9'h000, 9'h001, 9'h1FE, 9'h1FF, 9'h1FF};
	logic [8:0] rxLvl [5] = '{9'h000, 9'h001, 9'h0FE, 9'h0FF, 9'h100};
	logic [7:0] rxLvlExp [5] = '{8'h00, 8'h01, 8'hFE, 8'hFF, 8'hFF};

	// Short stuck count keeps the link scenarios brief
	ifs_status_regs #(.TX_DEPTH(`IFS_TX_DEPTH), .RX_DEPTH(`IFS_RX_DEPTH), .STUCK_CYCLES(4)) dut (
		.clk(clk), .srst(srst), .ce(ce), .linkClk(linkClk), .chainSerialInput(chainSerialInput),
		.linkCheckBitEvt(linkCheckBitEvt), .linkCrcEvt(linkCrcEvt), .hostEvt(hostEvt),
		.timeoutEnable(timeoutEnable), .txEvt(txEvt), .rxEvt(rxEvt), .txCount(txCount),
		.rxCount(rxCount), .clearAllFlags(clearAllFlags), .rdEn(rdEn), .rdAddr(rdAddr),
		.rdData(rdData), .rdValid(rdValid), .spiErrorSummary(spiErrorSummary),
		.chainErrorSummary(chainErrorSummary), .txQueueErrorSummary(txQueueErrorSummary),
		.rxQueueErrorSummary(rxQueueErrorSummary)
	);

	ifs_chain_model farEnd (
		.linkClk(linkClk), .stall(stall), .reqCheck(reqCheck), .reqCrc(reqCrc),
		.chainSerialInput(chainSerialInput), .checkBitEvt(linkCheckBitEvt), .crcEvt(linkCrcEvt)
	);

	// System clock 40 MHz, link clock 48 ns with no phase tie
	always #12.5 clk = ~clk;
	always #24 linkClk = ~linkClk;

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("failures=%0d comparisons=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One read: request for one cycle, answer a cycle later
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge clk);
		rdEn = 1'b1;
		rdAddr = a;
		@(negedge clk);
		rdEn = 1'b0;
		// Answer stands one cycle only, so look right after the taking edge
		`CHK(rdValid, 1'b1)
		`CHK(rdData, e)
	endtask

	// One-cycle event pulses on the host and queue inputs
	task automatic ev(input logic [2:0] h, input logic [2:0] t, input logic [2:0] r);
		@(negedge clk);
		hostEvt = h;
		txEvt = t;
		rxEvt = r;
		@(negedge clk);
		hostEvt = 3'h0;
		txEvt = 3'h0;
		rxEvt = 3'h0;
	endtask

	// Clear-all-flags write, then every summary must drop
	task automatic clr();
		@(negedge clk);
		clearAllFlags = 1'b1;
		@(negedge clk);
		clearAllFlags = 1'b0;
		`CHK({spiErrorSummary, chainErrorSummary, txQueueErrorSummary, rxQueueErrorSummary}, 4'h0)
	endtask

	// Link events take a few cycles to cross; poll with a bound
	task automatic waitChain();
		int n;
		n = 0;
		while (chainErrorSummary !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		`CHK(chainErrorSummary, 1'b1)
	endtask

	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		srst = 1'b0;
		rd(8'h08, 16'h0000);
		rd(8'h09, 16'h0000);
		rd(8'h0A, 16'h0000);
		rd(8'h0B, 16'h0000);
		timeoutEnable = 1'b1;
		for (int i = 0; i < 3; i++) begin
			ev(3'h1 << i, 3'h0, 3'h0);
			repeat (3) @(negedge clk);
			rd(8'h08, ifExp[i]);
			`CHK(chainErrorSummary, 1'(i == 0))
			clr();
			rd(8'h08, 16'h0000);
		end
		timeoutEnable = 1'b0;
		ev(3'h2, 3'h0, 3'h0);
		rd(8'h08, 16'h0000);
		ce = 1'b0;
		ev(3'h4, 3'h0, 3'h0);
		ce = 1'b1;
		rd(8'h08, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			ev(3'h0, 3'h1 << i, 3'h1 << i);
			`CHK(txQueueErrorSummary, 1'b1)
			rd(8'h09, {3'h1 << i, 13'h0000});
			rd(8'h0A, {3'h1 << i, 13'h0000});
			clr();
		end
		// Event and clear in the same cycle: the event must survive
		@(negedge clk);
		hostEvt = 3'h4;
		clearAllFlags = 1'b1;
		@(negedge clk);
		hostEvt = 3'h0;
		clearAllFlags = 1'b0;
		rd(8'h08, 16'h0200);
		clr();
		for (int i = 0; i < 5; i++) begin
			txCount = txLvl[i];
			rxCount = rxLvl[i];
			repeat (2) @(negedge clk);
			rd(8'h09, {7'h00, txLvlExp[i]});
			rd(8'h0A, {8'h00, rxLvlExp[i]});
		end
		reqCheck = 1'b1;
		repeat (6) @(negedge clk);
		reqCheck = 1'b0;
		waitChain();
		rd(8'h08, 16'h0008);
		clr();
		reqCrc = 1'b1;
		repeat (6) @(negedge clk);
		reqCrc = 1'b0;
		waitChain();
		rd(8'h08, 16'h0002);
		clr();
		stall = 1'b1;
		waitChain();
		stall = 1'b0;
		repeat (8) @(negedge clk);
		rd(8'h08, 16'h0001);
		clr();
		// Reset in mid-run wipes a standing flag
		ev(3'h4, 3'h0, 3'h0);
		srst = 1'b1;
		// Long enough for the link side to clear its toggles before release
		repeat (10) @(negedge clk);
		srst = 1'b0;
		rd(8'h08, 16'h0000);
		`CHK(spiErrorSummary, 1'b0)
		report_and_stop();
	end
endmodule // tb_top

// [verilog/ifs_chain_monitor.sv]
`timescale 1ns/1ps
`include "ifs_params.svh"

// Link-clock side: watches the chain serial input for missing edges
module ifs_chain_monitor #(
	parameter int STUCK_CYCLES = `IFS_STUCK_CYCLES
) (
	input wire logic linkClk,
	input wire logic srst,
	input wire logic chainSerialInput,
	output logic linkRst,
	output logic stuckPulse
);
	localparam int CNT_W = $clog2(STUCK_CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(STUCK_CYCLES - 1);

	logic rstMeta;
	logic inMeta;
	logic inSync;
	logic inPrev;
	logic [CNT_W-1:0] quietCount;
	logic edgeSeen;
	logic limitHit;
	logic [CNT_W-1:0] next_quietCount;

	if (STUCK_CYCLES < 2) begin : g_bad_limit
		$error("STUCK_CYCLES must be at least 2");
	end

	// Reset and pin both pass two flops before use
	always_ff @(posedge linkClk) begin
		rstMeta <= srst;
		linkRst <= rstMeta;
		inMeta <= chainSerialInput;
		inSync <= inMeta;
	end

	// Quiet counter stops at the limit so the event fires once per fault
	assign edgeSeen = inSync ^ inPrev;
	assign limitHit = (quietCount == LAST) && !edgeSeen;
	assign next_quietCount = edgeSeen ? '0 : (quietCount == CNT_W'(STUCK_CYCLES)) ? quietCount : quietCount + 1'b1;

	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			inPrev <= 1'b0;
			quietCount <= '0;
			stuckPulse <= 1'b0;
		end else begin
			inPrev <= inSync;
			quietCount <= next_quietCount;
			stuckPulse <= limitHit;
		end
	end

	a_stuck_once: assert property (@(posedge linkClk) disable iff (linkRst)
		stuckPulse |=> !stuckPulse)
		else $error("stuck event repeated");
	a_stuck_clears: assert property (@(posedge linkClk) disable iff (linkRst)
		edgeSeen |=> quietCount == '0)
		else $error("quiet count not restarted on input edge");
endmodule // ifs_chain_monitor

// [verilog/ifs_params.svh]
`ifndef IFS_PARAMS_SVH
`define IFS_PARAMS_SVH

// Register addresses on the status read port
`define IFS_ADDR_IF_ERR 8'h08
`define IFS_ADDR_TX_QUEUE 8'h09
`define IFS_ADDR_RX_QUEUE 8'h0A

// Common reset value of all three registers
`define IFS_REG_RESET 16'h0000

// Interface error status bit positions
`define IFS_BIT_CS_ABORT 9
`define IFS_BIT_SPI_TIMEOUT 8
`define IFS_BIT_CMD_QUEUE_OVF 4
`define IFS_BIT_CHECK_BIT 3
`define IFS_BIT_CHAIN_CRC 1
`define IFS_BIT_INPUT_STUCK 0

// Queue status bit positions, shared by both queue registers
`define IFS_BIT_Q_OVERFLOW 15
`define IFS_BIT_Q_UNDERFLOW 14
`define IFS_BIT_Q_ONE_BIT 13

// Fill level fields and their saturation codes
`define IFS_TX_LEVEL_W 9
`define IFS_RX_LEVEL_W 8
`define IFS_TX_LEVEL_SAT 9'h1FF
`define IFS_RX_LEVEL_SAT 8'hFF

// Documented queue depths
`define IFS_TX_DEPTH 512
`define IFS_RX_DEPTH 256

// Link clock cycles without an input edge before the line counts as stuck
`define IFS_STUCK_CYCLES 64

`endif

// [verilog/ifs_pkg.sv]
package ifs_pkg;

	// Events raised by the host-side command logic
	typedef struct packed {
		logic csAbort;
		logic spiTimeout;
		logic cmdQueueOverflow;
	} ifs_host_evt_t;

	// Error events of one data queue
	typedef struct packed {
		logic overflow;
		logic underflow;
		logic oneBitFault;
	} ifs_queue_evt_t;

	// Chain link events, already moved into the system clock domain
	typedef struct packed {
		logic checkBit;
		logic crc;
		logic stuck;
	} ifs_chain_evt_t;

endpackage

// [verilog/ifs_pulse_sync.sv]
`timescale 1ns/1ps

// Moves a one-cycle pulse from the link domain into the system domain
module ifs_pulse_sync (
	input wire logic srcClk,
	input wire logic srcRst,
	input wire logic srcPulse,
	input wire logic dstClk,
	input wire logic dstRst,
	input wire logic dstCe,
	output logic dstPulse
);
	logic srcToggle;
	logic syncA;
	logic syncB;
	logic syncC;

	// Toggle per event; pulses must be a few system cycles apart
	// Reset must reach this flop before srst drops, else a cleared toggle reads as an event
	always_ff @(posedge srcClk) begin
		if (srcRst) begin
			srcToggle <= 1'b0;
		end else if (srcPulse) begin
			srcToggle <= ~srcToggle;
		end
	end

	// Frozen by the enable, so a pending edge waits instead of being lost
	always_ff @(posedge dstClk) begin
		if (dstRst) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			syncC <= 1'b0;
		end else if (dstCe) begin
			syncA <= srcToggle;
			syncB <= syncA;
			syncC <= syncB;
		end
	end

	assign dstPulse = syncB ^ syncC;
endmodule // ifs_pulse_sync

// [verilog/ifs_status_regs.sv]
`timescale 1ns/1ps
`include "ifs_params.svh"

// Notes on behaviour
// - A chip select released mid-command sets the select-abort flag, bit 9 of interface status.
// - An SPI timeout sets bit 8 only while the timeout enable is high, otherwise it stays clear.
// - An overflow of the outgoing chain command queue sets bit 4.
// - A check bit error on chain receive data sets bit 3.
// - A CRC error on chain link data sets bit 1.
// - A chain serial input that stops toggling sets bit 0 as a stuck-at fault.
// - Transmit queue status shows overflow in 15, underflow in 14, single error in 13, all read-only.
// - Transmit status bits 8-0 hold the word count, 0x1FF standing for 511 or 512 words.
// - Receive queue status shows overflow in 15, underflow in 14, single error in 13, all read-only.
// - Receive status bits 7-0 hold the word count, 0xFF standing for 255 or 256 words.
// - Interface status at address 0x8 resets to zero and its reserved bits read zero.
// - Any chain link error also raises the chain error summary bit.
// - Any transmit queue error raises the transmit queue summary bit.
// - The clear-all-flags write clears every error flag held here.
module ifs_status_regs #(
	parameter int TX_DEPTH = `IFS_TX_DEPTH,
	parameter int RX_DEPTH = `IFS_RX_DEPTH,
	parameter int STUCK_CYCLES = `IFS_STUCK_CYCLES,
	localparam int TX_CNT_W = $clog2(TX_DEPTH + 1),
	localparam int RX_CNT_W = $clog2(RX_DEPTH + 1)
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic linkClk,
	input wire logic chainSerialInput,
	input wire logic linkCheckBitEvt,
	input wire logic linkCrcEvt,
	input wire ifs_pkg::ifs_host_evt_t hostEvt,
	input wire logic timeoutEnable,
	input wire ifs_pkg::ifs_queue_evt_t txEvt,
	input wire ifs_pkg::ifs_queue_evt_t rxEvt,
	input wire logic [TX_CNT_W-1:0] txCount,
	input wire logic [RX_CNT_W-1:0] rxCount,
	input wire logic clearAllFlags,
	input wire logic rdEn,
	input wire logic [7:0] rdAddr,
	output logic [15:0] rdData,
	output logic rdValid,
	output logic spiErrorSummary,
	output logic chainErrorSummary,
	output logic txQueueErrorSummary,
	output logic rxQueueErrorSummary
);
	if (TX_DEPTH < 2 || TX_DEPTH > `IFS_TX_DEPTH) begin : g_bad_tx
		$error("TX_DEPTH must lie in 2..512, the level field is 9 bits");
	end
	if (RX_DEPTH < 2 || RX_DEPTH > `IFS_RX_DEPTH) begin : g_bad_rx
		$error("RX_DEPTH must lie in 2..256, the level field is 8 bits");
	end

	// Flag update: an event in the clearing cycle wins over the clear
	function automatic logic stickyNext(input logic flag, input logic evt, input logic clr);
		return evt | (flag & ~clr);
	endfunction

	// Level code: the top code covers both the last two fill counts
	function automatic logic [9:0] levelCode(input logic [9:0] count, input logic [9:0] top);
		return (count > top) ? top : count;
	endfunction

	logic linkRst;
	logic stuckLink;
	logic [2:0] linkPulses;
	logic [2:0] sysPulses;
	ifs_pkg::ifs_chain_evt_t chainEvt;

	logic csAbortFlag;
	logic spiTimeoutFlag;
	logic cmdQueueOverflowFlag;
	logic chainCheckBitFlag;
	logic chainCrcFlag;
	logic chainInputStuckFlag;
	logic txOverflowFlag;
	logic txUnderflowFlag;
	logic txOneBitFaultFlag;
	logic rxOverflowFlag;
	logic rxUnderflowFlag;
	logic rxOneBitFaultFlag;
	logic [`IFS_TX_LEVEL_W-1:0] txFillLevel;
	logic [`IFS_RX_LEVEL_W-1:0] rxFillLevel;

	logic clr;
	logic timeoutEvt;
	logic next_csAbortFlag;
	logic next_spiTimeoutFlag;
	logic next_cmdQueueOverflowFlag;
	logic next_chainCheckBitFlag;
	logic next_chainCrcFlag;
	logic next_chainInputStuckFlag;
	logic next_txOverflowFlag;
	logic next_txUnderflowFlag;
	logic next_txOneBitFaultFlag;
	logic next_rxOverflowFlag;
	logic next_rxUnderflowFlag;
	logic next_rxOneBitFaultFlag;
	logic [9:0] txCode;
	logic [9:0] rxCode;
	logic [15:0] ifWord;
	logic [15:0] txWord;
	logic [15:0] rxWord;
	logic [15:0] next_rdData;

	// Link side watcher for the serial input
	ifs_chain_monitor #(
		.STUCK_CYCLES(STUCK_CYCLES)
	) u_monitor (
		.linkClk(linkClk),
		.srst(srst),
		.chainSerialInput(chainSerialInput),
		.linkRst(linkRst),
		.stuckPulse(stuckLink)
	);

	// All three link events cross by toggle synchronisers
	// srst must outlast three link clocks so the toggles are cleared before release
	assign linkPulses = {linkCheckBitEvt, linkCrcEvt, stuckLink};
	for (genvar i = 0; i < 3; i++) begin : g_cross
		ifs_pulse_sync u_sync (
			.srcClk(linkClk),
			.srcRst(linkRst),
			.srcPulse(linkPulses[i]),
			.dstClk(clk),
			.dstRst(srst),
			.dstCe(ce),
			.dstPulse(sysPulses[i])
		);
	end
	assign chainEvt = sysPulses;

	// Next flag values
	assign clr = clearAllFlags;
	assign timeoutEvt = hostEvt.spiTimeout & timeoutEnable;
	assign next_csAbortFlag = stickyNext(csAbortFlag, hostEvt.csAbort, clr);
	assign next_spiTimeoutFlag = stickyNext(spiTimeoutFlag, timeoutEvt, clr);
	assign next_cmdQueueOverflowFlag = stickyNext(cmdQueueOverflowFlag, hostEvt.cmdQueueOverflow, clr);
	assign next_chainCheckBitFlag = stickyNext(chainCheckBitFlag, chainEvt.checkBit, clr);
	assign next_chainCrcFlag = stickyNext(chainCrcFlag, chainEvt.crc, clr);
	assign next_chainInputStuckFlag = stickyNext(chainInputStuckFlag, chainEvt.stuck, clr);
	assign next_txOverflowFlag = stickyNext(txOverflowFlag, txEvt.overflow, clr);
	assign next_txUnderflowFlag = stickyNext(txUnderflowFlag, txEvt.underflow, clr);
	assign next_txOneBitFaultFlag = stickyNext(txOneBitFaultFlag, txEvt.oneBitFault, clr);
	assign next_rxOverflowFlag = stickyNext(rxOverflowFlag, rxEvt.overflow, clr);
	assign next_rxUnderflowFlag = stickyNext(rxUnderflowFlag, rxEvt.underflow, clr);
	assign next_rxOneBitFaultFlag = stickyNext(rxOneBitFaultFlag, rxEvt.oneBitFault, clr);

	// Fill level codes, saturating at the top code
	assign txCode = levelCode(10'(txCount), 10'(`IFS_TX_LEVEL_SAT));
	assign rxCode = levelCode(10'(rxCount), 10'(`IFS_RX_LEVEL_SAT));

	// Register images; bits not placed here read zero
	assign ifWord = (16'(csAbortFlag) << `IFS_BIT_CS_ABORT)
		| (16'(spiTimeoutFlag) << `IFS_BIT_SPI_TIMEOUT)
		| (16'(cmdQueueOverflowFlag) << `IFS_BIT_CMD_QUEUE_OVF)
		| (16'(chainCheckBitFlag) << `IFS_BIT_CHECK_BIT)
		| (16'(chainCrcFlag) << `IFS_BIT_CHAIN_CRC)
		| (16'(chainInputStuckFlag) << `IFS_BIT_INPUT_STUCK);
	assign txWord = (16'(txOverflowFlag) << `IFS_BIT_Q_OVERFLOW)
		| (16'(txUnderflowFlag) << `IFS_BIT_Q_UNDERFLOW)
		| (16'(txOneBitFaultFlag) << `IFS_BIT_Q_ONE_BIT)
		| 16'(txFillLevel);
	assign rxWord = (16'(rxOverflowFlag) << `IFS_BIT_Q_OVERFLOW)
		| (16'(rxUnderflowFlag) << `IFS_BIT_Q_UNDERFLOW)
		| (16'(rxOneBitFaultFlag) << `IFS_BIT_Q_ONE_BIT)
		| 16'(rxFillLevel);

	// Read decode; unmapped addresses answer zero
	assign next_rdData = (rdAddr == `IFS_ADDR_IF_ERR) ? ifWord :
		(rdAddr == `IFS_ADDR_TX_QUEUE) ? txWord :
		(rdAddr == `IFS_ADDR_RX_QUEUE) ? rxWord : `IFS_REG_RESET;

	// Interface error flags
	always_ff @(posedge clk) begin
		if (srst) begin
			csAbortFlag <= 1'b0;
			spiTimeoutFlag <= 1'b0;
			cmdQueueOverflowFlag <= 1'b0;
			chainCheckBitFlag <= 1'b0;
			chainCrcFlag <= 1'b0;
			chainInputStuckFlag <= 1'b0;
		end else if (ce) begin
			csAbortFlag <= next_csAbortFlag;
			spiTimeoutFlag <= next_spiTimeoutFlag;
			cmdQueueOverflowFlag <= next_cmdQueueOverflowFlag;
			chainCheckBitFlag <= next_chainCheckBitFlag;
			chainCrcFlag <= next_chainCrcFlag;
			chainInputStuckFlag <= next_chainInputStuckFlag;
		end
	end

	// Queue flags and fill levels
	always_ff @(posedge clk) begin
		if (srst) begin
			{txOverflowFlag, txUnderflowFlag, txOneBitFaultFlag} <= 3'h0;
			{rxOverflowFlag, rxUnderflowFlag, rxOneBitFaultFlag} <= 3'h0;
			txFillLevel <= '0;
			rxFillLevel <= '0;
		end else if (ce) begin
			{txOverflowFlag, txUnderflowFlag, txOneBitFaultFlag} <=
				{next_txOverflowFlag, next_txUnderflowFlag, next_txOneBitFaultFlag};
			{rxOverflowFlag, rxUnderflowFlag, rxOneBitFaultFlag} <=
				{next_rxOverflowFlag, next_rxUnderflowFlag, next_rxOneBitFaultFlag};
			txFillLevel <= txCode[`IFS_TX_LEVEL_W-1:0];
			rxFillLevel <= rxCode[`IFS_RX_LEVEL_W-1:0];
		end
	end

	// Summaries are taken from next values so they move with the flags
	always_ff @(posedge clk) begin
		if (srst) begin
			spiErrorSummary <= 1'b0;
			chainErrorSummary <= 1'b0;
			txQueueErrorSummary <= 1'b0;
			rxQueueErrorSummary <= 1'b0;
		end else if (ce) begin
			spiErrorSummary <= next_csAbortFlag | next_spiTimeoutFlag;
			chainErrorSummary <= next_cmdQueueOverflowFlag | next_chainCheckBitFlag
				| next_chainCrcFlag | next_chainInputStuckFlag;
			txQueueErrorSummary <= next_txOverflowFlag | next_txUnderflowFlag | next_txOneBitFaultFlag;
			rxQueueErrorSummary <= next_rxOverflowFlag | next_rxUnderflowFlag | next_rxOneBitFaultFlag;
		end
	end

	// Read port: data one cycle after the request, reads have no side effect
	always_ff @(posedge clk) begin
		if (srst) begin
			rdValid <= 1'b0;
			rdData <= `IFS_REG_RESET;
		end else if (ce) begin
			rdValid <= rdEn;
			if (rdEn) begin
				rdData <= next_rdData;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_cs_abort_set: assert property (ce && hostEvt.csAbort |=> csAbortFlag)
		else $error("select abort not flagged");
	a_timeout_set: assert property (ce && hostEvt.spiTimeout && timeoutEnable |=> spiTimeoutFlag)
		else $error("enabled timeout not flagged");
	a_timeout_gated: assert property (!spiTimeoutFlag && !(ce && hostEvt.spiTimeout && timeoutEnable)
		|=> !spiTimeoutFlag)
		else $error("timeout flag set without enabled timeout");
	a_queue_ovf_set: assert property (ce && hostEvt.cmdQueueOverflow |=> ifWord[`IFS_BIT_CMD_QUEUE_OVF])
		else $error("command queue overflow not flagged");
	a_check_bit_set: assert property (ce && chainEvt.checkBit |=> chainCheckBitFlag)
		else $error("check bit error not flagged");
	a_chain_crc_set: assert property (ce && chainEvt.crc |=> chainCrcFlag)
		else $error("chain crc error not flagged");
	a_stuck_reach: assert property ($rose(stuckLink) ##0 ce [*8] |-> ##[1:8] chainInputStuckFlag)
		else $error("stuck input not flagged in time");
	a_tx_flags_read: assert property (ce && txEvt.overflow ##1 ce && rdEn && rdAddr == `IFS_ADDR_TX_QUEUE
		|=> rdData[`IFS_BIT_Q_OVERFLOW])
		else $error("tx overflow not visible on read");
	a_tx_level_sat: assert property (ce && txCount >= TX_CNT_W'(`IFS_TX_LEVEL_SAT)
		|=> txFillLevel == `IFS_TX_LEVEL_SAT)
		else $error("tx level not saturated");
	a_rx_flags_read: assert property (ce && rxEvt.underflow ##1 ce && rdEn && rdAddr == `IFS_ADDR_RX_QUEUE
		|=> rdData[`IFS_BIT_Q_UNDERFLOW])
		else $error("rx underflow not visible on read");
	a_rx_level_track: assert property (ce && rxCount < RX_CNT_W'(`IFS_RX_LEVEL_SAT)
		|=> rxFillLevel == $past(rxCount[`IFS_RX_LEVEL_W-1:0]))
		else $error("rx level wrong");
	a_reserved_zero: assert property (ifWord[15:10] == 6'h00 && ifWord[7:5] == 3'h0
		&& ifWord[2] == 1'b0)
		else $error("reserved bit set");
	a_reset_clear: assert property (@(posedge clk) $fell(srst) |-> ifWord == `IFS_REG_RESET)
		else $error("interface status not zero after reset");
	a_chain_summary: assert property (chainErrorSummary == (cmdQueueOverflowFlag | chainCheckBitFlag
		| chainCrcFlag | chainInputStuckFlag))
		else $error("chain summary disagrees with flags");
	a_tx_summary: assert property (txQueueErrorSummary == (txOverflowFlag | txUnderflowFlag
		| txOneBitFaultFlag))
		else $error("tx summary disagrees with flags");
	a_clear_all: assert property (ce && clearAllFlags && hostEvt == '0 && chainEvt == '0
		&& txEvt == '0 && rxEvt == '0 |=> ifWord == '0 && txWord[15:13] == 3'h0
		&& rxWord[15:13] == 3'h0)
		else $error("flags survive clear");
	a_flags_sticky: assert property (!(ce && clearAllFlags) |=> (ifWord & $past(ifWord)) == $past(ifWord))
		else $error("flag dropped without clear");
	a_read_answer: assert property (ce && rdEn |=> rdValid)
		else $error("read not answered");

	// Read port shape: one answer per request, unmapped words read zero
	a_read_idle: assert property (ce && !rdEn
		|=> !rdValid)
		else $error("read answered without request");
	a_unmapped_zero: assert property (ce && rdEn && rdAddr != `IFS_ADDR_IF_ERR
		&& rdAddr != `IFS_ADDR_TX_QUEUE && rdAddr != `IFS_ADDR_RX_QUEUE |=> rdData == `IFS_REG_RESET)
		else $error("unmapped address read non-zero");
	a_if_read_image: assert property (ce && rdEn && rdAddr == `IFS_ADDR_IF_ERR
		|=> rdData == $past(ifWord))
		else $error("interface status read wrong");

	// Fill levels follow the counts and saturate at the top code
	a_tx_level_track: assert property (ce && txCount < TX_CNT_W'(`IFS_TX_LEVEL_SAT)
		|=> txFillLevel == $past(txCount[`IFS_TX_LEVEL_W-1:0]))
		else $error("tx level wrong");
	a_rx_level_sat: assert property (ce && rxCount >= RX_CNT_W'(`IFS_RX_LEVEL_SAT)
		|=> rxFillLevel == `IFS_RX_LEVEL_SAT)
		else $error("rx level not saturated");
	a_queue_reserved: assert property (txWord[`IFS_BIT_Q_ONE_BIT-1:`IFS_TX_LEVEL_W] == '0
		&& rxWord[`IFS_BIT_Q_ONE_BIT-1:`IFS_RX_LEVEL_W] == '0)
		else $error("queue reserved bit set");

	// Flags and summaries rise the cycle after their event
	a_tx_fault_set: assert property (ce && txEvt.oneBitFault
		|=> txWord[`IFS_BIT_Q_ONE_BIT])
		else $error("tx single error not flagged");
	a_rx_ovf_set: assert property (ce && rxEvt.overflow
		|=> rxWord[`IFS_BIT_Q_OVERFLOW])
		else $error("rx overflow not flagged");
	a_stuck_set: assert property (ce && chainEvt.stuck
		|=> chainInputStuckFlag)
		else $error("stuck input not flagged");
	a_crc_summary: assert property (ce && chainEvt.crc
		|=> chainErrorSummary)
		else $error("chain summary missed crc error");
	a_tx_evt_summary: assert property (ce && txEvt != '0
		|=> txQueueErrorSummary)
		else $error("tx summary missed queue error");
	a_timeout_blocked: assert property (ce && hostEvt.spiTimeout && !timeoutEnable && !spiTimeoutFlag
		|=> !spiTimeoutFlag)
		else $error("disabled timeout flagged");

	// Clear drops summaries, an event in the clear cycle survives, a low enable freezes
	a_clear_summary: assert property (ce && clearAllFlags && hostEvt == '0 && chainEvt == '0
		&& txEvt == '0 |=> !chainErrorSummary && !txQueueErrorSummary)
		else $error("summary survives clear");
	a_set_beats_clear: assert property (ce && clearAllFlags && hostEvt.csAbort
		|=> csAbortFlag)
		else $error("event lost in clear cycle");
	a_ce_freeze: assert property (!ce
		|=> $stable(ifWord) && $stable(txWord) && $stable(rxWord) && $stable(rdValid))
		else $error("state moved while enable low");

	c_clear_with_event: cover property (ce && clearAllFlags && hostEvt.csAbort);
	c_tx_full: cover property (ce && txCount == TX_CNT_W'(TX_DEPTH));
	c_stuck_flag: cover property ($rose(chainInputStuckFlag));
	c_timeout_blocked: cover property (ce && hostEvt.spiTimeout && !timeoutEnable);
	c_chain_crc: cover property (ce && chainEvt.crc);
endmodule // ifs_status_regs
